// ### src/sonet_receive_input_framing_status.sv
// Receive input interface: byte or bit-serial capture, framing,
// OOF/LOF/LOS status, line AIS request and transmit ring port sampling.
// Assumes all pins are synchronous to aclk; pin clocks are edge-sampled.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "rx_frame_defs.svh"
`default_nettype none

module sonet_receive_input_framing_status
  import rx_frame_pkg::*;
#(
  parameter int LOF_CYC = `LOF_TIME_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int LOS_CYC = `LOS_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int WIN_CYC = `LOS_WIN_US * 1000 / `CLK_PERIOD_NS
) (
  input  wire logic        aclk,                      // System clock
  input  wire logic        aresetn,                   // Sync reset
  input  wire logic [7:0]  s_axi_awaddr,              // Write address
  input  wire logic        s_axi_awvalid,             // Write addr valid
  output logic             s_axi_awready,             // Write addr ready
  input  wire logic [31:0] s_axi_wdata,               // Write data
  input  wire logic [3:0]  s_axi_wstrb,               // Byte enables
  input  wire logic        s_axi_wvalid,              // Write data valid
  output logic             s_axi_wready,              // Write data ready
  output logic [1:0]       s_axi_bresp,               // Write response
  output logic             s_axi_bvalid,              // Response valid
  input  wire logic        s_axi_bready,              // Response ready
  input  wire logic [7:0]  s_axi_araddr,              // Read address
  input  wire logic        s_axi_arvalid,             // Read addr valid
  output logic             s_axi_arready,             // Read addr ready
  output logic [31:0]      s_axi_rdata,               // Read data
  output logic [1:0]       s_axi_rresp,               // Read response
  output logic             s_axi_rvalid,              // Read valid
  input  wire logic        s_axi_rready,              // Read ready
  input  wire logic        byte_receive_clock,        // Byte clock pin
  input  wire logic [7:0]  receive_byte_bus,          // Byte stream
  input  wire logic        receive_frame_marker,      // Frame position
  input  wire logic        serial_receive_clock,      // Serial clock pin
  input  wire logic        serial_receive_bit,        // Serial stream
  input  wire logic        ais_request_ring_clock,    // Shared pin
  input  wire logic        tx_ring_port_frame_marker, // Ring frame pos
  input  wire logic        tx_ring_port_serial_data,  // Ring data
  input  wire logic        incoming_line_ais,         // Line AIS seen
  output logic             receive_byte_output_clock, // Output clock
  output logic [7:0]       rx_byte,                   // Captured byte
  output logic             rx_byte_valid,             // Byte pulse
  output logic             out_of_frame,              // OOF
  output logic             loss_of_frame,             // LOF
  output logic             loss_of_signal,            // LOS
  output logic             line_ais_insert,           // Force AIS
  output logic             ring_frame_bit,            // Ring frame bit
  output logic             ring_data_bit,             // Ring data bit
  output logic             ring_bit_strobe            // Ring bit pulse
);

  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  ctrl_t       ctrl_r;
  status_t     stat;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        serial;

  // Word indices of the two registers, sized to the decoded address bits
  localparam logic [5:0] CTRL_WORD = 6'(`REG_CTRL >> 2);
  localparam logic [5:0] STAT_WORD = 6'(`REG_STATUS >> 2);

  assign serial        = ctrl_r.mode == MODE_STS1_SERIAL;
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
    end
    else if (aw_hold_r && w_hold_r && !s_axi_bvalid)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
    end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
      ctrl_r       <= ctrl_t'(`CTRL_RESET);
    end
    else if (aw_hold_r && w_hold_r && !s_axi_bvalid)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `AXI_OKAY;
      // Mode, ring enable and auto AIS all live in byte lane 0
      if (awaddr_r[7:2] == CTRL_WORD)
      begin
        if (wstrb0_r)
          ctrl_r <= ctrl_t'(wdata_r[3:0]);
      end
      else if (awaddr_r[7:2] != STAT_WORD)
        s_axi_bresp <= `AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      case (s_axi_araddr[7:2])
        CTRL_WORD: s_axi_rdata <= {28'h0, ctrl_r};
        STAT_WORD: s_axi_rdata <= {28'h0, stat};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ----------------------------------------
  // Pin clock edges and byte capture
  // ----------------------------------------
  logic       bclk_q, sclk_q, rclk_q;
  logic       bclk_rise, sclk_rise, rclk_rise;
  logic [6:0] sr_r;
  logic [2:0] ser_cnt_r;
  logic       cap_mark_r, ais_req_r;

  assign bclk_rise = byte_receive_clock && !bclk_q;
  assign sclk_rise = serial_receive_clock && !sclk_q;
  assign rclk_rise = ais_request_ring_clock && !rclk_q;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      bclk_q <= 1'b0;
      sclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end
    else
    begin
      bclk_q <= byte_receive_clock;
      sclk_q <= serial_receive_clock;
      rclk_q <= ais_request_ring_clock;
    end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
      cap_mark_r    <= 1'b0;
      sr_r          <= 7'h00;
      ser_cnt_r     <= 3'd0;
    end
    else if (serial)
    begin
      rx_byte_valid <= 1'b0;
      cap_mark_r    <= 1'b0;
      if (sclk_rise)
      begin
        sr_r      <= {sr_r[5:0], serial_receive_bit};
        ser_cnt_r <= ser_cnt_r + 3'd1;
        if (ser_cnt_r == 3'd7)
        begin
          // First bit received ends up in bit 7
          rx_byte       <= {sr_r, serial_receive_bit};
          rx_byte_valid <= 1'b1;
        end
      end
    end
    else
    begin
      rx_byte_valid <= bclk_rise;
      if (bclk_rise)
      begin
        rx_byte    <= receive_byte_bus;
        cap_mark_r <= receive_frame_marker;
      end
    end

  // Byte modes simply echo the byte clock
  always_ff @(posedge aclk)
    if (!aresetn)
      receive_byte_output_clock <= 1'b0;
    else if (!serial)
      receive_byte_output_clock <= bclk_q;
    else if (sclk_rise && ser_cnt_r[1:0] == 2'd3)
      receive_byte_output_clock <= !receive_byte_output_clock;

  // ----------------------------------------
  // Shared pin: AIS request or ring clock
  // ----------------------------------------
  always_ff @(posedge aclk)
    if (!aresetn)
      ais_req_r <= 1'b0;
    else if (ctrl_r.ring_en)
      ais_req_r <= 1'b0;
    else if (bclk_rise)
      ais_req_r <= ais_request_ring_clock;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ring_frame_bit  <= 1'b0;
      ring_data_bit   <= 1'b0;
      ring_bit_strobe <= 1'b0;
    end
    else
    begin
      ring_bit_strobe <= ctrl_r.ring_en && rclk_rise;
      if (ctrl_r.ring_en && rclk_rise)
      begin
        ring_frame_bit <= tx_ring_port_frame_marker;
        ring_data_bit  <= tx_ring_port_serial_data;
      end
    end

  // ----------------------------------------
  // Frame alignment
  // ----------------------------------------
  logic [7:0]  prev_r;
  logic [13:0] pos_r, flen;
  logic        word_ok, at_exp;

  always_comb
    case (ctrl_r.mode)
      MODE_STS3_BYTE:  flen = `FLEN_STS3;
      MODE_STS12_BYTE: flen = `FLEN_STS12;
      default:         flen = `FLEN_STS1;
    endcase

  // Serial mode has no marker, so the pattern alone qualifies
  assign word_ok = prev_r == `A1_BYTE && rx_byte == `A2_BYTE
                   && (serial || cap_mark_r);
  assign at_exp  = pos_r == flen - 14'd1;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      prev_r       <= 8'h00;
      pos_r        <= 14'd0;
      out_of_frame <= 1'b1;
    end
    else if (rx_byte_valid)
    begin
      prev_r <= rx_byte;
      if (word_ok)
      begin
        pos_r        <= 14'd0;
        out_of_frame <= out_of_frame ? 1'b0 : !at_exp;
      end
      else if (cap_mark_r || at_exp)
      begin
        pos_r        <= 14'd0;
        out_of_frame <= 1'b1;
      end
      else
        pos_r <= pos_r + 14'd1;
    end

  // ----------------------------------------
  // Loss of frame and loss of signal
  // ----------------------------------------
  logic [19:0] lof_cnt_r;
  logic [19:0] zero_cnt_r;
  logic [19:0] win_cnt_r;
  logic        good_r, zero_viol;

  // Any return to the current state restarts the persistence timer
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      lof_cnt_r     <= 20'd0;
      loss_of_frame <= 1'b0;
    end
    else if (out_of_frame == loss_of_frame)
      lof_cnt_r <= 20'd0;
    else if (lof_cnt_r == 20'(LOF_CYC - 1))
    begin
      lof_cnt_r     <= 20'd0;
      loss_of_frame <= out_of_frame;
    end
    else
      lof_cnt_r <= lof_cnt_r + 20'd1;

  assign zero_viol = zero_cnt_r == 20'(LOS_CYC);

  always_ff @(posedge aclk)
    if (!aresetn)
      zero_cnt_r <= 20'd0;
    else if (rx_byte_valid && rx_byte != 8'h00)
      zero_cnt_r <= 20'd0;
    else if (!zero_viol)
      zero_cnt_r <= zero_cnt_r + 20'd1;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      loss_of_signal <= 1'b0;
      good_r         <= 1'b0;
      win_cnt_r      <= 20'd0;
    end
    else if (zero_viol)
    begin
      loss_of_signal <= 1'b1;
      good_r         <= 1'b0;
    end
    else if (rx_byte_valid && word_ok)
    begin
      win_cnt_r <= 20'd0;
      good_r    <= 1'b1;
      if (good_r)
        loss_of_signal <= 1'b0;
    end
    else if (win_cnt_r == 20'(WIN_CYC))
      good_r <= 1'b0;
    else
      win_cnt_r <= win_cnt_r + 20'd1;

  // ----------------------------------------
  // Line AIS insertion
  // ----------------------------------------
  always_ff @(posedge aclk)
    if (!aresetn)
      line_ais_insert <= 1'b0;
    else
      line_ais_insert <= (!ctrl_r.ring_en && ais_req_r)
        || (ctrl_r.auto_ais && (loss_of_signal || loss_of_frame
            || incoming_line_ais));

  assign stat = '{ais_insert: line_ais_insert, los: loss_of_signal,
                  lof: loss_of_frame, oof: out_of_frame};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ser_last;
    serial && sclk_rise && ser_cnt_r == 3'd7;
  endsequence

  sequence s_misplaced;
    rx_byte_valid && cap_mark_r && !word_ok && !at_exp;
  endsequence

  a_byte_capture: assert property (
    !serial && bclk_rise ##1 !serial |-> rx_byte_valid
      && rx_byte == $past(receive_byte_bus))
    else $error("byte bus not captured on clock edge");

  a_serial_order: assert property (
    s_ser_last ##1 serial |-> rx_byte_valid
      && rx_byte[0] == $past(serial_receive_bit))
    else $error("serial byte order wrong");

  a_oclk_divide: assert property (
    serial && sclk_rise && ser_cnt_r[1:0] == 2'd3 ##1 serial
      |-> receive_byte_output_clock != $past(receive_byte_output_clock))
    else $error("output clock not divided by eight");

  a_ais_request: assert property (
    !ctrl_r.ring_en && ais_req_r |=> line_ais_insert)
    else $error("AIS request did not force AIS");

  a_auto_ais: assert property (
    ctrl_r.auto_ais && (loss_of_frame || loss_of_signal)
      |=> line_ais_insert)
    else $error("automatic AIS missing");

  a_ring_sample: assert property (
    ctrl_r.ring_en && rclk_rise |=> ring_bit_strobe
      && ring_data_bit == $past(tx_ring_port_serial_data))
    else $error("ring data not sampled");

  a_oof_clear: assert property (
    rx_byte_valid && word_ok && out_of_frame |=> !out_of_frame)
    else $error("OOF not cleared on framing word");

  a_lof_set: assert property (
    out_of_frame && !loss_of_frame && lof_cnt_r == 20'(LOF_CYC - 1)
      |=> loss_of_frame)
    else $error("LOF not set after persistence");

  a_lof_hold: assert property (
    loss_of_frame && lof_cnt_r != 20'(LOF_CYC - 1) |=> loss_of_frame)
    else $error("LOF cleared early");

  a_los_set: assert property (
    zero_viol |=> loss_of_signal)
    else $error("LOS not set on zeros");

  a_resync: assert property (
    s_misplaced |=> out_of_frame && pos_r == 14'd0)
    else $error("misplaced marker not handled");

endmodule : sonet_receive_input_framing_status
`default_nettype wire

// ### src/rx_frame_defs.svh
// Constants for the receive input framing and status block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef RX_FRAME_DEFS_SVH
`define RX_FRAME_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define CTRL_RESET    4'h1
`define AXI_OKAY      2'b00
`define AXI_SLVERR    2'b10

// ----------------------------------------
// Framing pattern and frame lengths
// ----------------------------------------
`define A1_BYTE       8'hf6
`define A2_BYTE       8'h28
`define FLEN_STS1     14'd810
`define FLEN_STS3     14'd2430
`define FLEN_STS12    14'd9720

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define LOF_TIME_MS   3
`define LOS_TIME_US   20
`define LOS_WIN_US    125

`endif

// ### src/rx_frame_pkg.sv
// Types shared by the receive input framing block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rx_frame_pkg;
  typedef enum logic [1:0] {
    MODE_STS1_SERIAL,
    MODE_STS1_BYTE,
    MODE_STS3_BYTE,
    MODE_STS12_BYTE
  } rx_mode_t;

  typedef struct packed {
    logic     auto_ais;
    logic     ring_en;
    rx_mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic ais_insert;
    logic los;
    logic lof;
    logic oof;
  } status_t;
endpackage : rx_frame_pkg
`default_nettype wire

// ### tb/front_end_model.sv
// Front end model: byte clock, byte stream and frame marker.
// Assumes it is clocked by aclk; the byte clock runs at aclk/4.
`include "rx_frame_defs.svh"
`default_nettype none
module front_end_model
#(
  parameter int FLEN = 810
) (
  input  wire logic      aclk,      // Bench clock
  input  wire logic      run,       // Send frames
  input  wire logic      zeros,     // All-zero stream
  input  wire logic      bad_mark,  // Marker off position
  output var logic       bclk,      // Byte clock
  output var logic [7:0] bus,       // Byte stream
  output var logic       mark,      // Frame marker
  output var logic [7:0] last_byte  // Byte last offered
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  ph;
  logic [13:0] pos;
  logic [13:0] np;
  assign np = (pos == 14'(FLEN - 1)) ? 14'd0 : pos + 14'd1;
  initial
  begin
    {bclk, mark, ph, pos} = '0;
    bus = 8'h00;
    last_byte = 8'h00;
  end
  // Data changes two aclk before each clock rise, so it is settled
  always @(posedge aclk)
  begin
    if (!run)
    begin
      // Clock stands still; the bus does not keep showing old data
      bclk <= 1'b0;
      mark <= 1'b0;
      bus  <= ~bus;
      ph   <= 2'd0;
    end
    else
    begin
      ph <= ph + 2'd1;
      // Byte noted at the clock rise, so it matches the byte captured
      if (ph == 2'd2)
      begin
        bclk      <= 1'b1;
        last_byte <= bus;
      end
      if (ph == 2'd0)
      begin
        bclk      <= 1'b0;
        pos       <= np;
        mark      <= !zeros && (np == (bad_mark ? 14'd5 : 14'd1));
        if (zeros)
          bus <= 8'h00;
        else if (np == 14'd0)
          bus <= `A1_BYTE;
        else if (np == 14'd1)
          bus <= `A2_BYTE;
        else
          bus <= {np[6:0], 1'b1};  // Odd, so never A2
      end
    end
  end
endmodule : front_end_model
`default_nettype wire

// ### tb/tb_sonet_receive_input_framing_status.sv
// Self-checking bench for the receive framing and status block.
// Assumes the front end model drives the byte pins; AXI4-Lite from here.
`include "rx_frame_defs.svh"
`default_nettype none
module tb_sonet_receive_input_framing_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, incoming_line_ais = 1'b0;
  logic        serial_receive_clock = 1'b0, serial_receive_bit = 1'b0;
  logic        ais_request_ring_clock = 1'b0;
  logic        tx_ring_port_frame_marker = 1'b0;
  logic        tx_ring_port_serial_data = 1'b0;
  logic        run = 1'b0, zeros = 1'b0, bad_mark = 1'b0, byte_chk = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, byte_receive_clock, receive_frame_marker;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  receive_byte_bus, rx_byte, last_byte, got_byte = 8'h00;
  logic        receive_byte_output_clock, rx_byte_valid, out_of_frame;
  logic        loss_of_frame, loss_of_signal, line_ais_insert;
  logic        ring_frame_bit, ring_data_bit, ring_bit_strobe;
  logic [1:0]  ring_got = 2'b00;
  logic        oclk_q = 1'b0;
  int          fails = 0, comparisons = 0, cycles = 0, toggles = 0, t0, n;

  // Short counts so that loss states are reached in a few dozen cycles, well inside one frame
  sonet_receive_input_framing_status
    #(.LOF_CYC(40), .LOS_CYC(20), .WIN_CYC(4000)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .byte_receive_clock, .receive_byte_bus,
    .receive_frame_marker, .serial_receive_clock, .serial_receive_bit,
    .ais_request_ring_clock, .tx_ring_port_frame_marker,
    .tx_ring_port_serial_data, .incoming_line_ais,
    .receive_byte_output_clock, .rx_byte, .rx_byte_valid, .out_of_frame,
    .loss_of_frame, .loss_of_signal, .line_ais_insert, .ring_frame_bit,
    .ring_data_bit, .ring_bit_strobe);

  front_end_model #(.FLEN(810)) fe_u (
    .aclk, .run, .zeros, .bad_mark, .bclk(byte_receive_clock),
    .bus(receive_byte_bus), .mark(receive_frame_marker), .last_byte);

  always #2 aclk = ~aclk;

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc

  // ----------------------------------------
  // Register bus and pin drivers
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {aw, w} = 2'b11;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", r, s_axi_bresp);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rdata", d, s_axi_rdata);
    check("rresp", r, s_axi_rresp);
  endtask : axi_rd

  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      serial_receive_bit   <= b[i];
      serial_receive_clock <= 1'b0;
      cyc(2);
      serial_receive_clock <= 1'b1;
      cyc(2);
    end
    cyc(3);
    check("ser_byte", b, got_byte);
  endtask : ser_byte

  task automatic ring_bit(input logic f, input logic d);
    {tx_ring_port_frame_marker, tx_ring_port_serial_data} <= {f, d};
    ais_request_ring_clock <= 1'b0;
    cyc(2);
    ais_request_ring_clock <= 1'b1;
    cyc(5);
    check("ring_bits", {f, d}, ring_got);
    check("ais_ring", 1'b0, line_ais_insert);
  endtask : ring_bit

  task automatic wait_oof(input logic v);
    n = 0;
    while (out_of_frame !== v && n < 9000)
    begin
      @(posedge aclk);
      n++;
    end
    check("oof", v, out_of_frame);
  endtask : wait_oof

  // Monitor; the run needs about 35000 cycles, so 60000 means a hang
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    oclk_q <= receive_byte_output_clock;
    if (oclk_q !== receive_byte_output_clock)
      toggles <= toggles + 1;
    if (rx_byte_valid)
      got_byte <= rx_byte;
    if (ring_bit_strobe)
      ring_got <= {ring_frame_bit, ring_data_bit};
    if (byte_chk && rx_byte_valid)
      check("rx_byte", last_byte, rx_byte);
    if (cycles == 60000)
    begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    cyc(8);
    aresetn <= 1'b1;
    check("oof_rst", 1'b1, out_of_frame);
    cyc(30);
    check("lof_early", 1'b0, loss_of_frame);
    cyc(20);
    check("lof_set", 1'b1, loss_of_frame);
    check("los_set", 1'b1, loss_of_signal);
    check("ais_off", 1'b0, line_ais_insert);
    axi_rd(`REG_CTRL, 32'h1, `AXI_OKAY);
    axi_wr(`REG_CTRL, 32'hfffffff9, 4'hf, `AXI_OKAY);
    axi_rd(`REG_CTRL, 32'h9, `AXI_OKAY);
    axi_rd(`REG_STATUS, 32'hf, `AXI_OKAY);
    axi_wr(`REG_CTRL, 32'h0, 4'h0, `AXI_OKAY);
    axi_rd(`REG_CTRL, 32'h9, `AXI_OKAY);
    axi_wr(`REG_CTRL, 32'h1, 4'h1, `AXI_OKAY);
    axi_wr(`REG_STATUS, 32'h0, 4'hf, `AXI_OKAY);
    axi_wr(8'h08, 32'h5, 4'hf, `AXI_SLVERR);
    axi_rd(8'h0c, 32'h0, `AXI_SLVERR);
    cyc(3);
    check("ais_auto_off", 1'b0, line_ais_insert);
    {run, byte_chk} <= 2'b11;
    wait_oof(1'b0);
    check("los_one_word", 1'b1, loss_of_signal);
    cyc(20);
    check("lof_hold", 1'b1, loss_of_frame);
    cyc(30);
    check("lof_clr", 1'b0, loss_of_frame);
    cyc(3300);
    check("los_clr", 1'b0, loss_of_signal);
    check("oof_stay", 1'b0, out_of_frame);
    ais_request_ring_clock <= 1'b1;
    cyc(12);
    check("ais_req", 1'b1, line_ais_insert);
    ais_request_ring_clock <= 1'b0;
    cyc(12);
    check("ais_req_off", 1'b0, line_ais_insert);
    axi_wr(`REG_CTRL, 32'h9, 4'hf, `AXI_OKAY);
    cyc(3);
    check("ais_clean", 1'b0, line_ais_insert);
    incoming_line_ais <= 1'b1;
    cyc(4);
    check("ais_line", 1'b1, line_ais_insert);
    incoming_line_ais <= 1'b0;
    axi_wr(`REG_CTRL, 32'h1, 4'hf, `AXI_OKAY);
    bad_mark <= 1'b1;
    wait_oof(1'b1);
    bad_mark <= 1'b0;
    wait_oof(1'b0);
    // Longer frame modes must reject the 810-byte frame spacing
    for (int m = 2; m < 4; m++)
    begin
      axi_wr(`REG_CTRL, 32'(m), 4'h1, `AXI_OKAY);
      wait_oof(1'b1);
      axi_wr(`REG_CTRL, 32'h1, 4'h1, `AXI_OKAY);
      wait_oof(1'b0);
    end
    zeros <= 1'b1;
    cyc(40);
    check("los_zeros", 1'b1, loss_of_signal);
    zeros <= 1'b0;
    cyc(7000);
    check("los_back", 1'b0, loss_of_signal);
    axi_wr(`REG_CTRL, 32'h5, 4'hf, `AXI_OKAY);
    ring_bit(1'b1, 1'b0);
    ring_bit(1'b0, 1'b1);
    {run, byte_chk, ais_request_ring_clock} <= 3'b000;
    axi_wr(`REG_CTRL, 32'h0, 4'hf, `AXI_OKAY);
    cyc(4);
    t0 = toggles;
    ser_byte(8'ha5);
    ser_byte(8'h3c);
    check("oclk_div", 32'd4, 32'(toggles - t0));
    complete_run();
  end
endmodule : tb_sonet_receive_input_framing_status
`default_nettype wire
